/* File: hdl/pipc_top.sv */
`timescale 1ns/1ps
// Behaviour
// - pull disable bit 6 turns off the external pin pull while the pin function is on
// - polarity bit 5: 0 falling edge or low level, 1 rising edge or high level
// - enabled pin pulls down for rising polarity, up for falling, unless pull disabled
// - pin acts as interrupt input only while function enable bit 4 is set
// - event flag bit 3 sets on a qualifying event and stays until acknowledged
// - writing 1 to ack bit 2 clears the flag; 0 does nothing; reads 0
// - in edge-and-level mode the flag stays set while the pin is asserted
// - enable bit 1 requests an interrupt whenever the flag is set
// - mode bit 0: 0 edge only, 1 edge and level, with chosen polarity
// - per-pin pull enable; output pins keep the pull off
// - port pull is a pull-down only for interrupt pins selecting rising polarity
// - per-pin slew control enable, no effect on input pins
// - per-pin drive select, 0 low and 1 high, no effect on input pins
// - port flag bit 3 reports an event, ignores writes; bits 7 to 4 read 0
// - writing 1 to port ack bit 2 clears the port flag; reads 0
// - port enable bit 1 gates the port interrupt request
// - port mode bit 0: 0 edges only, 1 edges and levels, per-pin polarity
module pipc_top #(
	parameter int PORT_WIDTH = 8
) (
	// clock and reset
	input  wire logic                  i_clk,
	input  wire logic                  i_rst,
	// wishbone slave
	input  wire logic                  i_wb_cyc,
	input  wire logic                  i_wb_stb,
	input  wire logic                  i_wb_we,
	input  wire logic [7:0]            i_wb_adr,
	input  wire logic [3:0]            i_wb_sel,
	input  wire logic [31:0]           i_wb_dat,
	output logic      [31:0]           o_wb_dat,
	output logic                       o_wb_ack,
	// external interrupt pin
	input  wire logic                  i_ext_pin,
	output logic                       o_ext_pull_en,
	output logic                       o_ext_pull_up,
	output logic                       o_ext_irq,
	// port pins and pad controls
	input  wire logic [PORT_WIDTH-1:0] i_port_pin,
	output logic      [PORT_WIDTH-1:0] o_port_out,
	output logic      [PORT_WIDTH-1:0] o_port_oe,
	output logic      [PORT_WIDTH-1:0] o_port_pull_en,
	output logic      [PORT_WIDTH-1:0] o_port_pull_up,
	output logic      [PORT_WIDTH-1:0] o_port_slew_en,
	output logic      [PORT_WIDTH-1:0] o_port_drive_high,
	output logic                       o_port_irq
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	localparam int PAD_W = pipc_pkg::WB_DATA_W - PORT_WIDTH;

	pipc_pkg::pipc_wb_state_e wb_state_r;
	logic [31:0]              wb_dat_r;
	logic [31:0]              wb_dat_nxt;
	logic                     wb_ack_r;
	logic                     wb_req;
	logic                     wb_wr;

	// external pin control fields
	logic ext_pull_disable_r;
	logic ext_polarity_r;
	logic ext_func_enable_r;
	logic ext_event_flag_r;
	logic ext_event_flag_nxt;
	logic ext_int_enable_r;
	logic ext_detect_mode_r;
	logic ext_ack_wr;

	// port registers
	logic [PORT_WIDTH-1:0] port_pull_enable_r;
	logic [PORT_WIDTH-1:0] port_slew_enable_r;
	logic [PORT_WIDTH-1:0] port_drive_select_r;
	logic [PORT_WIDTH-1:0] port_pin_edge_select_r;
	logic [PORT_WIDTH-1:0] port_int_select_r;
	logic [PORT_WIDTH-1:0] port_direction_r;
	logic [PORT_WIDTH-1:0] port_data_out_r;
	logic                  port_int_flag_r;
	logic                  port_int_flag_nxt;
	logic                  port_int_enable_r;
	logic                  port_detect_mode_r;
	logic                  port_ack_wr;

	// synchronised pins and detection
	logic                  ext_level;
	logic                  ext_level_prev;
	logic                  ext_asserted;
	logic                  ext_asserted_prev;
	logic                  ext_event;
	logic [PORT_WIDTH-1:0] port_level;
	logic [PORT_WIDTH-1:0] port_level_prev;
	logic [PORT_WIDTH-1:0] port_asserted;
	logic [PORT_WIDTH-1:0] port_asserted_prev;
	logic [PORT_WIDTH-1:0] port_pin_event;
	logic                  port_event;

	// pad control next values and their output registers
	logic [PORT_WIDTH-1:0] port_pull_en_nxt;
	logic [PORT_WIDTH-1:0] port_pull_up_nxt;
	logic [PORT_WIDTH-1:0] port_slew_en_nxt;
	logic [PORT_WIDTH-1:0] port_drive_high_nxt;
	logic [PORT_WIDTH-1:0] port_pull_en_r;
	logic [PORT_WIDTH-1:0] port_pull_up_r;
	logic [PORT_WIDTH-1:0] port_slew_en_r;
	logic [PORT_WIDTH-1:0] port_drive_high_r;
	logic [PORT_WIDTH-1:0] port_out_r;
	logic [PORT_WIDTH-1:0] port_oe_r;
	logic                  ext_pull_en_r;
	logic                  ext_pull_up_r;
	logic                  ext_irq_r;
	logic                  port_irq_r;

	// elaboration check: the port must fit the low byte lane
	if (PORT_WIDTH < 1 || PORT_WIDTH > pipc_pkg::PORT_MAX_W) begin : g_chk
		$error("pipc_top: PORT_WIDTH must be 1 to 8");
	end

	// ****************************************************************
	// wishbone slave
	// ****************************************************************

	// request seen only in idle so each cycle is answered once
	assign wb_req     = i_wb_cyc && i_wb_stb && (wb_state_r == pipc_pkg::WB_IDLE);
	assign wb_wr      = wb_req && i_wb_we && i_wb_sel[0];
	assign ext_ack_wr = wb_wr && (i_wb_adr == pipc_pkg::OFS_EXT_INT_PIN_CTRL)
	                    && i_wb_dat[pipc_pkg::EXT_EVENT_ACK_BIT];
	assign port_ack_wr = wb_wr && (i_wb_adr == pipc_pkg::OFS_PORT_INT_CTRL)
	                     && i_wb_dat[pipc_pkg::PORT_INT_ACK_BIT];

	// one-cycle ack, dropped in the following cycle
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wb_state_r <= pipc_pkg::WB_IDLE;
			wb_ack_r   <= 1'b0;
		end else begin
			case (wb_state_r)
				pipc_pkg::WB_IDLE: begin
					wb_ack_r <= wb_req;
					if (wb_req) begin
						wb_state_r <= pipc_pkg::WB_ACK;
					end
				end
				pipc_pkg::WB_ACK: begin
					wb_ack_r   <= 1'b0;
					wb_state_r <= pipc_pkg::WB_IDLE;
				end
				default: begin
					wb_ack_r   <= 1'b0;
					wb_state_r <= pipc_pkg::WB_IDLE;
				end
			endcase
		end
	end

	// read mux; ack bits and reserved bits read zero, unmapped reads zero
	always_comb begin
		wb_dat_nxt = 32'h0000_0000;
		case (i_wb_adr)
			pipc_pkg::OFS_EXT_INT_PIN_CTRL: begin
				wb_dat_nxt[pipc_pkg::EXT_PULL_DISABLE_BIT] = ext_pull_disable_r;
				wb_dat_nxt[pipc_pkg::EXT_POLARITY_BIT]     = ext_polarity_r;
				wb_dat_nxt[pipc_pkg::EXT_FUNC_ENABLE_BIT]  = ext_func_enable_r;
				wb_dat_nxt[pipc_pkg::EXT_EVENT_FLAG_BIT]   = ext_event_flag_r;
				wb_dat_nxt[pipc_pkg::EXT_INT_ENABLE_BIT]   = ext_int_enable_r;
				wb_dat_nxt[pipc_pkg::EXT_DETECT_MODE_BIT]  = ext_detect_mode_r;
			end
			pipc_pkg::OFS_PORT_INT_CTRL: begin
				wb_dat_nxt[pipc_pkg::PORT_INT_FLAG_BIT]    = port_int_flag_r;
				wb_dat_nxt[pipc_pkg::PORT_INT_ENABLE_BIT]  = port_int_enable_r;
				wb_dat_nxt[pipc_pkg::PORT_DETECT_MODE_BIT] = port_detect_mode_r;
			end
			pipc_pkg::OFS_PORT_PULL_ENABLE:  wb_dat_nxt = {{PAD_W{1'b0}}, port_pull_enable_r};
			pipc_pkg::OFS_PORT_SLEW_ENABLE:  wb_dat_nxt = {{PAD_W{1'b0}}, port_slew_enable_r};
			pipc_pkg::OFS_PORT_DRIVE_SELECT: wb_dat_nxt = {{PAD_W{1'b0}}, port_drive_select_r};
			pipc_pkg::OFS_PORT_EDGE_SELECT:  wb_dat_nxt = {{PAD_W{1'b0}}, port_pin_edge_select_r};
			pipc_pkg::OFS_PORT_INT_SELECT:   wb_dat_nxt = {{PAD_W{1'b0}}, port_int_select_r};
			pipc_pkg::OFS_PORT_DIRECTION:    wb_dat_nxt = {{PAD_W{1'b0}}, port_direction_r};
			pipc_pkg::OFS_PORT_DATA_OUT:     wb_dat_nxt = {{PAD_W{1'b0}}, port_data_out_r};
			pipc_pkg::OFS_PORT_PIN_STATE:    wb_dat_nxt = {{PAD_W{1'b0}}, port_level};
			default:                         wb_dat_nxt = 32'h0000_0000;
		endcase
	end

	// read data captured with the ack
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wb_dat_r <= 32'h0000_0000;
		end else if (wb_req && !i_wb_we) begin
			wb_dat_r <= wb_dat_nxt;
		end
	end

	// ****************************************************************
	// control registers
	// ****************************************************************

	// external pin control; flag bit is not writable
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ext_pull_disable_r <= pipc_pkg::RST_EXT_INT_PIN_CTRL[pipc_pkg::EXT_PULL_DISABLE_BIT];
			ext_polarity_r     <= pipc_pkg::RST_EXT_INT_PIN_CTRL[pipc_pkg::EXT_POLARITY_BIT];
			ext_func_enable_r  <= pipc_pkg::RST_EXT_INT_PIN_CTRL[pipc_pkg::EXT_FUNC_ENABLE_BIT];
			ext_int_enable_r   <= pipc_pkg::RST_EXT_INT_PIN_CTRL[pipc_pkg::EXT_INT_ENABLE_BIT];
			ext_detect_mode_r  <= pipc_pkg::RST_EXT_INT_PIN_CTRL[pipc_pkg::EXT_DETECT_MODE_BIT];
		end else if (wb_wr && i_wb_adr == pipc_pkg::OFS_EXT_INT_PIN_CTRL) begin
			ext_pull_disable_r <= i_wb_dat[pipc_pkg::EXT_PULL_DISABLE_BIT];
			ext_polarity_r     <= i_wb_dat[pipc_pkg::EXT_POLARITY_BIT];
			ext_func_enable_r  <= i_wb_dat[pipc_pkg::EXT_FUNC_ENABLE_BIT];
			ext_int_enable_r   <= i_wb_dat[pipc_pkg::EXT_INT_ENABLE_BIT];
			ext_detect_mode_r  <= i_wb_dat[pipc_pkg::EXT_DETECT_MODE_BIT];
		end
	end

	// port interrupt control; flag bit is not writable
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			port_int_enable_r  <= pipc_pkg::RST_PORT_INT_CTRL[pipc_pkg::PORT_INT_ENABLE_BIT];
			port_detect_mode_r <= pipc_pkg::RST_PORT_INT_CTRL[pipc_pkg::PORT_DETECT_MODE_BIT];
		end else if (wb_wr && i_wb_adr == pipc_pkg::OFS_PORT_INT_CTRL) begin
			port_int_enable_r  <= i_wb_dat[pipc_pkg::PORT_INT_ENABLE_BIT];
			port_detect_mode_r <= i_wb_dat[pipc_pkg::PORT_DETECT_MODE_BIT];
		end
	end

	// per-pin port configuration registers
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			port_pull_enable_r     <= pipc_pkg::RST_PORT_PULL_ENABLE[PORT_WIDTH-1:0];
			port_slew_enable_r     <= pipc_pkg::RST_PORT_SLEW_ENABLE[PORT_WIDTH-1:0];
			port_drive_select_r    <= pipc_pkg::RST_PORT_DRIVE_SELECT[PORT_WIDTH-1:0];
			port_pin_edge_select_r <= pipc_pkg::RST_PORT_EDGE_SELECT[PORT_WIDTH-1:0];
			port_int_select_r      <= pipc_pkg::RST_PORT_INT_SELECT[PORT_WIDTH-1:0];
			port_direction_r       <= pipc_pkg::RST_PORT_DIRECTION[PORT_WIDTH-1:0];
			port_data_out_r        <= pipc_pkg::RST_PORT_DATA_OUT[PORT_WIDTH-1:0];
		end else if (wb_wr) begin
			case (i_wb_adr)
				pipc_pkg::OFS_PORT_PULL_ENABLE:  port_pull_enable_r     <= i_wb_dat[PORT_WIDTH-1:0];
				pipc_pkg::OFS_PORT_SLEW_ENABLE:  port_slew_enable_r     <= i_wb_dat[PORT_WIDTH-1:0];
				pipc_pkg::OFS_PORT_DRIVE_SELECT: port_drive_select_r    <= i_wb_dat[PORT_WIDTH-1:0];
				pipc_pkg::OFS_PORT_EDGE_SELECT:  port_pin_edge_select_r <= i_wb_dat[PORT_WIDTH-1:0];
				pipc_pkg::OFS_PORT_INT_SELECT:   port_int_select_r      <= i_wb_dat[PORT_WIDTH-1:0];
				pipc_pkg::OFS_PORT_DIRECTION:    port_direction_r       <= i_wb_dat[PORT_WIDTH-1:0];
				pipc_pkg::OFS_PORT_DATA_OUT:     port_data_out_r        <= i_wb_dat[PORT_WIDTH-1:0];
				default: begin
				end
			endcase
		end
	end

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************

	// external interrupt pin
	pipc_pin_sync #(
		.WIDTH(1)
	) u_ext_sync (
		.i_clk        (i_clk),
		.i_rst        (i_rst),
		.i_pin        (i_ext_pin),
		.o_level      (ext_level),
		.o_level_prev (ext_level_prev)
	);

	// port pins
	pipc_pin_sync #(
		.WIDTH(PORT_WIDTH)
	) u_port_sync (
		.i_clk        (i_clk),
		.i_rst        (i_rst),
		.i_pin        (i_port_pin),
		.o_level      (port_level),
		.o_level_prev (port_level_prev)
	);

	// ****************************************************************
	// event detection
	// ****************************************************************

	// both samples judged with the current polarity, so a polarity write makes no edge
	assign ext_asserted      = ext_polarity_r ? ext_level : ~ext_level;
	assign ext_asserted_prev = ext_polarity_r ? ext_level_prev : ~ext_level_prev;
	assign ext_event         = ext_func_enable_r
	                           && (ext_detect_mode_r ? ext_asserted
	                                                 : (ext_asserted && !ext_asserted_prev));

	// per-pin polarity, edge or level, and pad control
	for (genvar g = 0; g < PORT_WIDTH; g++) begin : g_pin
		assign port_asserted[g]      = port_pin_edge_select_r[g] ? port_level[g] : ~port_level[g];
		assign port_asserted_prev[g] = port_pin_edge_select_r[g] ? port_level_prev[g] : ~port_level_prev[g];
		assign port_pin_event[g]     = port_int_select_r[g]
		                               && (port_detect_mode_r ? port_asserted[g]
		                                                      : (port_asserted[g] && !port_asserted_prev[g]));
		assign port_pull_en_nxt[g]    = port_pull_enable_r[g] && !port_direction_r[g];
		assign port_pull_up_nxt[g]    = !(port_int_select_r[g] && port_pin_edge_select_r[g]);
		assign port_slew_en_nxt[g]    = port_slew_enable_r[g] && port_direction_r[g];
		assign port_drive_high_nxt[g] = port_drive_select_r[g] && port_direction_r[g];
	end

	assign port_event = |port_pin_event;

	// ****************************************************************
	// sticky event flags
	// ****************************************************************

	// set wins over ack; a held level keeps setting, so ack cannot clear it
	assign ext_event_flag_nxt  = ext_event || (ext_event_flag_r && !ext_ack_wr);
	assign port_int_flag_nxt   = port_event || (port_int_flag_r && !port_ack_wr);

	// flag registers
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ext_event_flag_r <= pipc_pkg::RST_EXT_INT_PIN_CTRL[pipc_pkg::EXT_EVENT_FLAG_BIT];
			port_int_flag_r  <= pipc_pkg::RST_PORT_INT_CTRL[pipc_pkg::PORT_INT_FLAG_BIT];
		end else begin
			ext_event_flag_r <= ext_event_flag_nxt;
			port_int_flag_r  <= port_int_flag_nxt;
		end
	end

	// ****************************************************************
	// output registers
	// ****************************************************************

	// interrupt requests follow the flags one cycle later
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ext_irq_r  <= 1'b0;
			port_irq_r <= 1'b0;
		end else begin
			ext_irq_r  <= ext_event_flag_r && ext_int_enable_r;
			port_irq_r <= port_int_flag_r && port_int_enable_r;
		end
	end

	// external pin pull: only while the function is on and not disabled
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ext_pull_en_r <= 1'b0;
			ext_pull_up_r <= 1'b1;
		end else begin
			ext_pull_en_r <= ext_func_enable_r && !ext_pull_disable_r;
			ext_pull_up_r <= !ext_polarity_r;
		end
	end

	// port pad controls and output drivers
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			port_pull_en_r    <= '0;
			port_pull_up_r    <= '1;
			port_slew_en_r    <= '0;
			port_drive_high_r <= '0;
			port_out_r        <= '0;
			port_oe_r         <= '0;
		end else begin
			port_pull_en_r    <= port_pull_en_nxt;
			port_pull_up_r    <= port_pull_up_nxt;
			port_slew_en_r    <= port_slew_en_nxt;
			port_drive_high_r <= port_drive_high_nxt;
			port_out_r        <= port_data_out_r;
			port_oe_r         <= port_direction_r;
		end
	end

	assign o_wb_dat          = wb_dat_r;
	assign o_wb_ack          = wb_ack_r;
	assign o_ext_pull_en     = ext_pull_en_r;
	assign o_ext_pull_up     = ext_pull_up_r;
	assign o_ext_irq         = ext_irq_r;
	assign o_port_out        = port_out_r;
	assign o_port_oe         = port_oe_r;
	assign o_port_pull_en    = port_pull_en_r;
	assign o_port_pull_up    = port_pull_up_r;
	assign o_port_slew_en    = port_slew_en_r;
	assign o_port_drive_high = port_drive_high_r;
	assign o_port_irq        = port_irq_r;

endmodule : pipc_top

/* File: common/pipc_pkg.sv */
// ****************************************************************
// register map and field layout
// ****************************************************************
package pipc_pkg;

	// byte offsets on the wishbone register bus
	localparam logic [7:0] OFS_EXT_INT_PIN_CTRL  = 8'h00;
	localparam logic [7:0] OFS_PORT_PULL_ENABLE  = 8'h04;
	localparam logic [7:0] OFS_PORT_SLEW_ENABLE  = 8'h08;
	localparam logic [7:0] OFS_PORT_DRIVE_SELECT = 8'h0C;
	localparam logic [7:0] OFS_PORT_INT_CTRL     = 8'h10;
	localparam logic [7:0] OFS_PORT_EDGE_SELECT  = 8'h14;
	localparam logic [7:0] OFS_PORT_INT_SELECT   = 8'h18;
	localparam logic [7:0] OFS_PORT_DIRECTION    = 8'h1C;
	localparam logic [7:0] OFS_PORT_DATA_OUT     = 8'h20;
	localparam logic [7:0] OFS_PORT_PIN_STATE    = 8'h24;

	// ext_int_pin_ctrl field positions
	localparam int EXT_PULL_DISABLE_BIT = 6;
	localparam int EXT_POLARITY_BIT     = 5;
	localparam int EXT_FUNC_ENABLE_BIT  = 4;
	localparam int EXT_EVENT_FLAG_BIT   = 3;
	localparam int EXT_EVENT_ACK_BIT    = 2;
	localparam int EXT_INT_ENABLE_BIT   = 1;
	localparam int EXT_DETECT_MODE_BIT  = 0;

	// port_int_ctrl field positions
	localparam int PORT_INT_FLAG_BIT    = 3;
	localparam int PORT_INT_ACK_BIT     = 2;
	localparam int PORT_INT_ENABLE_BIT  = 1;
	localparam int PORT_DETECT_MODE_BIT = 0;

	// values after reset
	localparam logic [7:0] RST_EXT_INT_PIN_CTRL  = 8'h00;
	localparam logic [7:0] RST_PORT_PULL_ENABLE  = 8'h00;
	localparam logic [7:0] RST_PORT_SLEW_ENABLE  = 8'h00;
	localparam logic [7:0] RST_PORT_DRIVE_SELECT = 8'h00;
	localparam logic [7:0] RST_PORT_INT_CTRL     = 8'h00;
	localparam logic [7:0] RST_PORT_EDGE_SELECT  = 8'h00;
	localparam logic [7:0] RST_PORT_INT_SELECT   = 8'h00;
	localparam logic [7:0] RST_PORT_DIRECTION    = 8'h00;
	localparam logic [7:0] RST_PORT_DATA_OUT     = 8'h00;

	// bus data width and largest port the byte lane can hold
	localparam int WB_DATA_W     = 32;
	localparam int PORT_MAX_W    = 8;
	localparam int SYNC_STAGES   = 2;

	// wishbone slave states
	typedef enum logic [0:0] {
		WB_IDLE,
		WB_ACK
	} pipc_wb_state_e;

endpackage : pipc_pkg

/* File: hdl/pipc_pin_sync.sv */
`timescale 1ns/1ps
// ****************************************************************
// pin synchroniser with one extra stage for edge history
// ****************************************************************
module pipc_pin_sync #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	// raw pins
	input  wire logic [WIDTH-1:0] i_pin,
	// synchronised level and the level one cycle earlier
	output logic      [WIDTH-1:0] o_level,
	output logic      [WIDTH-1:0] o_level_prev
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] level_r;
	logic [WIDTH-1:0] prev_r;

	// elaboration check on width
	if (WIDTH < 1) begin : g_chk
		$error("pipc_pin_sync: WIDTH must be at least 1");
	end

	// two-flop crossing; first stage only feeds the second
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_r  <= '0;
			level_r <= '0;
		end else begin
			meta_r  <= i_pin;
			level_r <= meta_r;
		end
	end

	// history stage for edge detection
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			prev_r <= '0;
		end else begin
			prev_r <= level_r;
		end
	end

	assign o_level      = level_r;
	assign o_level_prev = prev_r;

endmodule : pipc_pin_sync

/* File: verif/pipc_top_monitor.sv */
`timescale 1ns/1ps
// ****************************************************************
// port checker for pipc_top
// ****************************************************************
module pipc_top_monitor #(
	parameter int PORT_WIDTH = 8
) (
	// clock, reset and bus
	input wire logic                  i_clk, i_rst, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack,
	input wire logic [7:0]            i_wb_adr,
	input wire logic [3:0]            i_wb_sel,
	input wire logic [31:0]           i_wb_dat, o_wb_dat,
	// pins and pads
	input wire logic                  i_ext_pin, o_ext_pull_en, o_ext_pull_up, o_ext_irq, o_port_irq,
	input wire logic [PORT_WIDTH-1:0] i_port_pin, o_port_out, o_port_oe, o_port_pull_en, o_port_pull_up,
	input wire logic [PORT_WIDTH-1:0] o_port_slew_en, o_port_drive_high
);
	logic [7:0]            sh [8];
	logic                  wr;
	logic [PORT_WIDTH-1:0] dir;
	logic [PORT_WIDTH-1:0] pdn;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// a write the slave takes, and the pad settings it implies
	assign wr = i_wb_cyc & i_wb_stb & i_wb_we & i_wb_sel[0] & !o_wb_ack;
	assign dir = sh[7][PORT_WIDTH-1:0];
	assign pdn = sh[5][PORT_WIDTH-1:0] & sh[6][PORT_WIDTH-1:0];
	// shadow of the writable registers at 0x00 to 0x1C
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int i = 0; i < 8; i++) sh[i] <= 8'h00;
		end else if (wr && i_wb_adr[7:5] == 3'h0 && i_wb_adr[1:0] == 2'h0) begin
			sh[i_wb_adr[4:2]] <= i_wb_dat[7:0];
		end
	end
	ext_pull_a: assert property (!$past(wr) |-> o_ext_pull_en == (sh[0][4] & !sh[0][6])
		&& (!o_ext_pull_en || o_ext_pull_up == !sh[0][5])) else $error("ext pull wrong");
	port_pull_a: assert property (!$past(wr) |-> o_port_pull_en == (sh[1][PORT_WIDTH-1:0] & ~dir)
		&& (o_port_pull_en & (o_port_pull_up ^ ~pdn)) == '0) else $error("port pull wrong");
	pad_ctl_a: assert property (!$past(wr) |-> o_port_oe == dir && o_port_slew_en == (sh[2][PORT_WIDTH-1:0] & dir)
		&& o_port_drive_high == (sh[3][PORT_WIDTH-1:0] & dir)) else $error("pad control wrong");
	ext_mask_a: assert property (!$past(wr) && !sh[0][1] |-> !o_ext_irq) else $error("ext irq unmasked");
	port_mask_a: assert property (!$past(wr) && !sh[4][1] |-> !o_port_irq) else $error("port irq unmasked");
	ext_read_a: assert property (o_wb_ack && !i_wb_we && i_wb_adr == 8'h00 |->
		{o_wb_dat[31:8], o_wb_dat[7:4], o_wb_dat[2:0]} == {25'h0, sh[0][6:4], 1'b0, sh[0][1:0]}) else $error("ext read");
	port_read_a: assert property (o_wb_ack && !i_wb_we && i_wb_adr == 8'h10 |->
		{o_wb_dat[31:4], o_wb_dat[2:0]} == {29'h0, sh[4][1:0]}) else $error("port read");
	ext_event_a: assert property (sh[0][4] && sh[0][1] && !sh[0][0]
		&& (sh[0][5] ? $rose(i_ext_pin) : $fell(i_ext_pin)) |-> ##[1:6] o_ext_irq) else $error("ext edge lost");
	ext_level_a: assert property ((sh[0][4] && sh[0][1] && sh[0][0] && i_ext_pin == sh[0][5]) [*6]
		|-> o_ext_irq) else $error("ext level lost");
endmodule : pipc_top_monitor

/* File: verif/pipc_pin_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// external devices on the interrupt pin and the port pins
// ****************************************************************
module pipc_pin_model (
	// clock
	input  wire logic       i_clk,
	// levels the devices want, and release of the interrupt line
	input  wire logic       i_ext_lvl,
	input  wire logic       i_ext_rel,
	input  wire logic [7:0] i_port_lvl,
	// pad state from the block
	input  wire logic       i_ext_pull_en,
	input  wire logic       i_ext_pull_up,
	input  wire logic [7:0] i_port_oe,
	input  wire logic [7:0] i_port_out,
	// resulting pin levels
	output logic            o_ext_pin,
	output logic      [7:0] o_port_pin
);
	logic churn_r = 1'b0;
	// a floating line with no pull wanders every cycle
	always_ff @(posedge i_clk) churn_r <= !churn_r;
	// a released line settles to the pull the block enables
	assign o_ext_pin = !i_ext_rel ? i_ext_lvl : i_ext_pull_en ? i_ext_pull_up : churn_r;
	// a pin the block drives reads back its own output
	assign o_port_pin = (i_port_oe & i_port_out) | (~i_port_oe & i_port_lvl);
endmodule : pipc_pin_model

/* File: verif/pipc_top_tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; $display("BAD %0t %h %h", $time, a, b); end end
// ****************************************************************
// testbench top
// ****************************************************************
module pipc_top_tb_top;
	localparam int PORT_WIDTH = 8;
	logic        i_clk = 1'b0, i_rst = 1'b1, i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
	logic [7:0]  i_wb_adr = 8'h00, port_lvl = 8'h00, i_port_pin, o_port_out, o_port_oe;
	logic [7:0]  o_port_pull_en, o_port_pull_up, o_port_slew_en, o_port_drive_high;
	logic [3:0]  i_wb_sel = 4'h0;
	logic [31:0] i_wb_dat = 32'h00000000, o_wb_dat, rd;
	logic        ext_lvl = 1'b0, ext_rel = 1'b0, o_wb_ack, i_ext_pin, o_ext_pull_en, o_ext_pull_up, o_ext_irq, o_port_irq;
	int          err_count = 0, n_compared = 0;
	pipc_top #(.PORT_WIDTH(PORT_WIDTH)) pipc_top_inst (.*);
	pipc_pin_model pipc_pin_model_inst (.i_clk(i_clk), .i_ext_lvl(ext_lvl), .i_ext_rel(ext_rel), .i_port_lvl(port_lvl),
		.i_ext_pull_en(o_ext_pull_en), .i_ext_pull_up(o_ext_pull_up), .i_port_oe(o_port_oe),
		.i_port_out(o_port_out), .o_ext_pin(i_ext_pin), .o_port_pin(i_port_pin));
	// clock
	initial forever #4 i_clk = ~i_clk;
	task automatic conclude;
		if (err_count == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : conclude
	// one classic cycle, waiting for ack under a bound
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		i_wb_cyc <= 1'b1; i_wb_stb <= 1'b1; i_wb_we <= w; i_wb_adr <= a; i_wb_sel <= 4'hF; i_wb_dat <= {24'h000000, d};
		do begin
			@(posedge i_clk);
			n++;
		end while (o_wb_ack !== 1'b1 && n < 20);
		rd = o_wb_dat;
		i_wb_cyc <= 1'b0; i_wb_stb <= 1'b0;
		@(posedge i_clk);
		if (n >= 20) begin err_count++; conclude(); end
	endtask : bus
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		`CHK(rd, {24'h000000, e})
	endtask : rchk
	// a pin change reaches the irq output four edges later
	task automatic settle;
		repeat (6) @(posedge i_clk);
	endtask : settle
	task automatic t_reset;
		for (int a = 0; a <= 40; a += 4) rchk(a[7:0], 8'h00);
		bus(1'b1, 8'h28, 8'hFF);
		rchk(8'h28, 8'h00);
	endtask : t_reset
	task automatic t_pads;
		bus(1'b1, pipc_pkg::OFS_PORT_SLEW_ENABLE, 8'hFF);
		bus(1'b1, pipc_pkg::OFS_PORT_DATA_OUT, 8'h05);
		bus(1'b1, pipc_pkg::OFS_PORT_PULL_ENABLE, 8'hFF);
		bus(1'b1, pipc_pkg::OFS_PORT_DRIVE_SELECT, 8'hAA);
		bus(1'b1, pipc_pkg::OFS_PORT_EDGE_SELECT, 8'h30);
		bus(1'b1, pipc_pkg::OFS_PORT_INT_SELECT, 8'h10);
		bus(1'b1, pipc_pkg::OFS_PORT_DIRECTION, 8'h0F);
		rchk(pipc_pkg::OFS_PORT_DIRECTION, 8'h0F);
		`CHK(o_port_pull_en, 8'hF0)
		`CHK(o_port_pull_en & o_port_pull_up, 8'hE0)
		`CHK(o_port_slew_en, 8'h0F)
		`CHK(o_port_drive_high, 8'h0A)
		`CHK(o_port_out, 8'h05)
		rchk(pipc_pkg::OFS_PORT_PIN_STATE, 8'h05);
		bus(1'b1, pipc_pkg::OFS_PORT_DIRECTION, 8'h00);
	endtask : t_pads
	task automatic t_ext_edge;
		bus(1'b1, 8'h00, 8'h32);
		ext_lvl <= 1'b1;
		settle();
		`CHK(o_ext_irq, 1'b1)
		`CHK({o_ext_pull_en, o_ext_pull_up}, 2'b10)
		bus(1'b1, 8'h00, 8'h32);
		rchk(8'h00, 8'h3A);
		bus(1'b1, 8'h00, 8'h36);
		settle();
		rchk(8'h00, 8'h32);
		ext_rel <= 1'b1;
		settle();
		rchk(8'h00, 8'h32);
		ext_lvl <= 1'b0;
		ext_rel <= 1'b0;
		bus(1'b1, 8'h00, 8'h72);
		`CHK(o_ext_pull_en, 1'b0)
	endtask : t_ext_edge
	task automatic t_ext_level;
		bus(1'b1, 8'h00, 8'h13);
		settle();
		rchk(8'h00, 8'h1B);
		bus(1'b1, 8'h00, 8'h17);
		rchk(8'h00, 8'h1B);
		ext_lvl <= 1'b1;
		settle();
		bus(1'b1, 8'h00, 8'h17);
		rchk(8'h00, 8'h13);
		bus(1'b1, 8'h00, 8'h01);
		ext_lvl <= 1'b0;
		settle();
		rchk(8'h00, 8'h01);
		`CHK(o_ext_irq, 1'b0)
	endtask : t_ext_level
	task automatic t_port;
		bus(1'b1, pipc_pkg::OFS_PORT_EDGE_SELECT, 8'h01);
		bus(1'b1, pipc_pkg::OFS_PORT_INT_SELECT, 8'h01);
		bus(1'b1, pipc_pkg::OFS_PORT_INT_CTRL, 8'h02);
		port_lvl <= 8'h02;
		settle();
		rchk(pipc_pkg::OFS_PORT_INT_CTRL, 8'h02);
		port_lvl <= 8'h03;
		settle();
		`CHK(o_port_irq, 1'b1)
		bus(1'b1, pipc_pkg::OFS_PORT_INT_CTRL, 8'h02);
		rchk(pipc_pkg::OFS_PORT_INT_CTRL, 8'h0A);
		bus(1'b1, pipc_pkg::OFS_PORT_INT_CTRL, 8'h07);
		rchk(pipc_pkg::OFS_PORT_INT_CTRL, 8'h0B);
		// leave level mode first: an ack in the same write still sees level mode
		bus(1'b1, pipc_pkg::OFS_PORT_INT_CTRL, 8'h02);
		bus(1'b1, pipc_pkg::OFS_PORT_INT_CTRL, 8'h04);
		rchk(pipc_pkg::OFS_PORT_INT_CTRL, 8'h00);
		`CHK(o_port_irq, 1'b0)
	endtask : t_port
	// main sequence
	initial begin
		repeat (10) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		t_reset();
		t_pads();
		t_ext_edge();
		t_ext_level();
		t_port();
		conclude();
	end
endmodule : pipc_top_tb_top
bind pipc_top pipc_top_monitor #(.PORT_WIDTH(PORT_WIDTH)) pipc_top_monitor_inst (.*);
